// ---- iosc_pkg.sv ----
package iosc_pkg;

   // Clock and time base
   localparam int CLK_HZ = 200_000_000;
   localparam int SAMPLE_RATE_HZ = 1000;
   localparam int DELAY_STEP_US = 100;
   localparam int STEP_CYCLES = CLK_HZ / 1_000_000 * DELAY_STEP_US;
   localparam int SAMPLE_STEPS = 1_000_000 / SAMPLE_RATE_HZ / DELAY_STEP_US;

   // Peripheral input and output word offsets
   localparam logic [3:0] OFS_AI_CH0 = 4'h0;
   localparam logic [3:0] OFS_AI_CH1 = 4'h2;
   localparam logic [3:0] OFS_AI_CH2 = 4'h4;
   localparam logic [3:0] OFS_AI_CH3 = 4'h6;
   localparam logic [3:0] OFS_TEMP_CH4 = 4'h8;
   localparam logic [3:0] OFS_AO_CH0 = 4'h0;
   localparam logic [3:0] OFS_AO_CH1 = 4'h2;

   // Channel counts
   localparam int N_AI = 4;
   localparam int N_AO = 2;
   localparam int N_DI = 24;
   localparam int DI_GROUP = 8;
   localparam int N_GROUPS = N_DI / DI_GROUP;
   localparam int N_DO = 16;

   // Interference suppression codes and averaging windows
   localparam logic [1:0] SUPP_400HZ = 2'h0;
   localparam logic [1:0] SUPP_60HZ = 2'h1;
   localparam logic [1:0] SUPP_50HZ = 2'h2;
   localparam logic [4:0] WIN_50HZ = 5'h14;
   localparam logic [4:0] WIN_60HZ = 5'h10;
   localparam int WIN_MAX = 20;
   // Integration time in units of 0.1 ms
   localparam logic [7:0] ITIME_400HZ = 8'h19;
   localparam logic [7:0] ITIME_60HZ = 8'hA6;
   localparam logic [7:0] ITIME_50HZ = 8'hC8;

   // Measurement type and range codes
   localparam logic [1:0] TYPE_DISABLED = 2'h0;
   localparam logic [1:0] TYPE_VOLTAGE = 2'h1;
   localparam logic [1:0] TYPE_CURRENT = 2'h2;
   localparam logic [1:0] TYPE_RESISTANCE = 2'h1;
   localparam logic [1:0] TYPE_THERMOCOUPLE = 2'h2;
   localparam logic [2:0] RANGE_DISABLED = 3'h0;
   localparam logic [2:0] RANGE_PM20MA = 3'h1;
   localparam logic [2:0] RANGE_0_20MA = 3'h2;
   localparam logic [2:0] RANGE_4_20MA = 3'h3;
   localparam logic [2:0] RANGE_PM10V = 3'h4;
   localparam logic [2:0] RANGE_0_10V = 3'h5;
   localparam logic [1:0] TRANGE_DISABLED = 2'h0;
   localparam logic [1:0] TRANGE_PT100 = 2'h1;
   localparam logic [1:0] TRANGE_600OHM = 2'h2;
   localparam logic [1:0] UNIT_CELSIUS = 2'h0;
   localparam logic [1:0] UNIT_FAHRENHEIT = 2'h1;
   localparam logic [1:0] UNIT_KELVIN = 2'h2;
   localparam logic [15:0] DISABLED_VALUE = 16'h7FFF;

   // Temperature conversion, values in 0.1 degree
   localparam logic signed [19:0] F_MUL = 20'sh0_0009;
   localparam logic signed [19:0] F_DIV = 20'sh0_0005;
   localparam logic signed [19:0] F_OFS = 20'sh0_0140;
   localparam logic signed [19:0] K_OFS = 20'sh0_0AAC;

   // Input delay codes and lengths in 0.1 ms steps
   localparam logic [1:0] DLY_0MS1 = 2'h0;
   localparam logic [1:0] DLY_0MS5 = 2'h1;
   localparam logic [1:0] DLY_3MS = 2'h2;
   localparam logic [1:0] DLY_15MS = 2'h3;
   localparam logic [7:0] DLY_STEPS_0MS1 = 8'h01;
   localparam logic [7:0] DLY_STEPS_0MS5 = 8'h05;
   localparam logic [7:0] DLY_STEPS_3MS = 8'h1E;
   localparam logic [7:0] DLY_STEPS_15MS = 8'h96;

   // Parameter record layout
   localparam logic [7:0] REC_NUM_PARAM = 8'h01;
   localparam logic [3:0] REC_LEN_DI = 4'hA;
   localparam logic [3:0] REC_LEN_AI = 4'hD;
   localparam int REC_MAX = 13;
   localparam int RB_DI_DELAY = 0;
   localparam int RB_DI_RISE = 2;
   localparam int RB_DI_FALL = 5;
   localparam int RB_AI_CH0 = 0;
   localparam int RB_TEMP = 4;
   localparam int RB_AO_CH0 = 5;

   typedef struct packed {
      logic [1:0] supp;
      logic [1:0] mtype;
      logic [2:0] mrange;
   } iosc_ai_cfg_t;

   typedef struct packed {
      logic [1:0] unit;
      logic [1:0] mtype;
      logic [1:0] mrange;
   } iosc_temp_cfg_t;

   typedef struct packed {
      logic [1:0] mtype;
      logic [2:0] mrange;
   } iosc_ao_cfg_t;

   localparam iosc_ai_cfg_t AI_CFG_DEFAULT = '{SUPP_50HZ, TYPE_VOLTAGE, RANGE_PM10V};
   localparam iosc_temp_cfg_t TEMP_CFG_DEFAULT = '{UNIT_CELSIUS, TYPE_RESISTANCE,
                                                   TRANGE_600OHM};
   localparam iosc_ao_cfg_t AO_CFG_DEFAULT = '{TYPE_VOLTAGE, RANGE_PM10V};

   typedef enum logic [1:0] {
      REC_IDLE = 2'b01,
      REC_RECV = 2'b10
   } iosc_rec_state_t;

endpackage

// ---- iosc_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Sample every analog channel at 1 kHz
// - Fresh value into input word each millisecond
// - Repeated reads return held value until update
// - 50 Hz: average twenty most recent samples
// - 400 Hz setting bypasses the averaging filter
// - Integration time follows suppression, default 50 Hz
// - Channels 0-3 range selectable, default +/-10 V
// - Channels 0-3 type selectable, default voltage
// - Temperature unit C/F/K, default Celsius
// - Channel 4 type and range, with defaults
// - Per-group input delay, default 3 ms
// - Per-input edge interrupt enables, default off
// - Inputs used by technology stay readable
// - Writes to technology-owned outputs ignored
// - Plain digital outputs have no parameters
// - Accept run-time parameter record number one
// - Digital input record is ten bytes
// - One pending edge per input, extras dropped
module iosc_top
   import iosc_pkg::*;
#(
   parameter int STEP_CYCLES_P = STEP_CYCLES
) (
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic [N_AI:0][15:0] AI_SAMPLE,
   output logic [N_AI-1:0][6:0] AI_CFG,
   output logic [N_AI-1:0][7:0] AI_INT_TIME,
   output logic [5:0] TEMP_CFG,
   output logic [N_AO-1:0][4:0] AO_CFG,
   output logic [N_AO-1:0][15:0] AO_VALUE,
   input wire logic RD_EN,
   input wire logic [3:0] RD_ADDR,
   output logic [15:0] RD_DATA,
   input wire logic WR_EN,
   input wire logic [3:0] WR_ADDR,
   input wire logic [15:0] WR_DATA,
   input wire logic REC_START,
   input wire logic [7:0] REC_NUMBER,
   input wire logic REC_TARGET,
   input wire logic REC_BYTE_VALID,
   input wire logic [7:0] REC_BYTE,
   output logic REC_DONE,
   output logic REC_ERROR,
   input wire logic [N_DI-1:0] DI_PIN,
   output logic [N_DI-1:0] DI_STATE,
   output logic [N_DI-1:0] IRQ_PENDING,
   input wire logic [N_DI-1:0] IRQ_ACK,
   input wire logic DO_USER_WR,
   input wire logic [N_DO-1:0] DO_USER_DATA,
   input wire logic [N_DO-1:0] TECH_DO_OWN,
   input wire logic [N_DO-1:0] TECH_DO_VALUE,
   output logic [N_DO-1:0] DO_PIN
);

   logic [31:0] step_cnt_reg;
   logic [7:0] sub_cnt_reg;
   logic step_tick;
   logic sample_tick;
   logic upd_reg;
   iosc_rec_state_t rec_state_reg;
   logic rec_tgt_reg;
   logic [3:0] rec_idx_reg;
   logic [3:0] rec_len;
   logic rec_last;
   logic [7:0] rec_buf [REC_MAX];
   iosc_ai_cfg_t [N_AI-1:0] ai_pend_reg;
   iosc_ai_cfg_t [N_AI-1:0] ai_act_reg;
   iosc_temp_cfg_t temp_pend_reg;
   iosc_temp_cfg_t temp_act_reg;
   iosc_ao_cfg_t [N_AO-1:0] ao_cfg_reg;
   logic [N_AO-1:0][15:0] ao_val_reg;
   logic [N_GROUPS-1:0][1:0] di_dly_reg;
   logic [N_DI-1:0] rise_en_reg;
   logic [N_DI-1:0] fall_en_reg;
   logic [N_AI-1:0][15:0] ai_value_reg;
   logic [15:0] temp_value_reg;
   logic signed [15:0] temp_smp_reg;
   logic [N_DO-1:0] do_user_reg;

   // Time base: 0.1 ms step for input delays, every tenth step a sample
   assign step_tick = (step_cnt_reg == 32'(STEP_CYCLES_P - 1));
   assign sample_tick = step_tick && (sub_cnt_reg == 8'(SAMPLE_STEPS - 1));

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         step_cnt_reg <= '0;
         sub_cnt_reg <= '0;
         upd_reg <= 1'b0;
      end else begin
         upd_reg <= sample_tick; // Results land one cycle after the sample
         if (step_tick) begin
            step_cnt_reg <= '0;
            sub_cnt_reg <= sample_tick ? 8'h00 : sub_cnt_reg + 8'h01; // 1 kHz
         end else begin
            step_cnt_reg <= step_cnt_reg + 32'h0000_0001;
         end
      end
   end

   // Parameter record receiver
   assign rec_len = rec_tgt_reg ? REC_LEN_AI : REC_LEN_DI;
   assign rec_last = (rec_state_reg == REC_RECV) && REC_BYTE_VALID && !REC_START &&
                     (rec_idx_reg == rec_len - 4'h1);

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         rec_state_reg <= REC_IDLE;
         rec_tgt_reg <= 1'b0;
         rec_idx_reg <= '0;
         REC_DONE <= 1'b0;
         REC_ERROR <= 1'b0;
      end else begin
         REC_DONE <= rec_last;
         REC_ERROR <= REC_START && (REC_NUMBER != REC_NUM_PARAM); // Only record one
         case (rec_state_reg)
            REC_IDLE: begin
               if (REC_START && REC_NUMBER == REC_NUM_PARAM) begin
                  rec_state_reg <= REC_RECV;
                  rec_tgt_reg <= REC_TARGET;
                  rec_idx_reg <= '0;
               end
            end
            REC_RECV: begin
               if (REC_START) begin
                  // A new start abandons a half-sent record
                  rec_state_reg <= (REC_NUMBER == REC_NUM_PARAM) ? REC_RECV : REC_IDLE;
                  rec_tgt_reg <= REC_TARGET;
                  rec_idx_reg <= '0;
               end else if (rec_last) begin
                  rec_state_reg <= REC_IDLE;
               end else if (REC_BYTE_VALID) begin
                  rec_idx_reg <= rec_idx_reg + 4'h1;
               end
            end
            default: begin
               rec_state_reg <= REC_IDLE;
            end
         endcase
      end
   end

   // Record staging bytes, no reset needed: only read after a full record
   always_ff @(posedge REF_CLK) begin
      if (rec_state_reg == REC_RECV && REC_BYTE_VALID && !REC_START) begin
         rec_buf[rec_idx_reg] <= REC_BYTE;
      end
   end

   // Digital input settings take effect as soon as the record is complete
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         for (int g = 0; g < N_GROUPS; g++) begin
            di_dly_reg[g] <= DLY_3MS;
         end
         rise_en_reg <= '0;
         fall_en_reg <= '0;
      end else if (REC_DONE && !rec_tgt_reg) begin
         for (int g = 0; g < N_GROUPS; g++) begin
            di_dly_reg[g] <= rec_buf[RB_DI_DELAY][2*g +: 2];
            rise_en_reg[g*DI_GROUP +: DI_GROUP] <= rec_buf[RB_DI_RISE + g];
            fall_en_reg[g*DI_GROUP +: DI_GROUP] <= rec_buf[RB_DI_FALL + g];
         end
      end
   end

   // Analog input settings are staged here and applied at the next sample; output settings apply at once
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         for (int c = 0; c < N_AI; c++) begin
            ai_pend_reg[c] <= AI_CFG_DEFAULT;
         end
         temp_pend_reg <= TEMP_CFG_DEFAULT;
         for (int a = 0; a < N_AO; a++) begin
            ao_cfg_reg[a] <= AO_CFG_DEFAULT;
         end
      end else if (REC_DONE && rec_tgt_reg) begin
         for (int c = 0; c < N_AI; c++) begin
            ai_pend_reg[c] <= iosc_ai_cfg_t'(rec_buf[RB_AI_CH0 + c][6:0]);
         end
         temp_pend_reg <= iosc_temp_cfg_t'(rec_buf[RB_TEMP][5:0]);
         for (int a = 0; a < N_AO; a++) begin
            ao_cfg_reg[a] <= iosc_ao_cfg_t'(rec_buf[RB_AO_CH0 + a][4:0]);
         end
      end
   end

   // Active settings switch only on a sample tick
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         for (int c = 0; c < N_AI; c++) begin
            ai_act_reg[c] <= AI_CFG_DEFAULT;
            AI_INT_TIME[c] <= ITIME_50HZ;
         end
         temp_act_reg <= TEMP_CFG_DEFAULT;
      end else if (sample_tick) begin
         for (int c = 0; c < N_AI; c++) begin
            ai_act_reg[c] <= ai_pend_reg[c];
            case (ai_pend_reg[c].supp)
               SUPP_400HZ: AI_INT_TIME[c] <= ITIME_400HZ;
               SUPP_60HZ: AI_INT_TIME[c] <= ITIME_60HZ;
               default: AI_INT_TIME[c] <= ITIME_50HZ;
            endcase
         end
         temp_act_reg <= temp_pend_reg;
      end
   end

   assign AI_CFG = ai_act_reg;
   assign TEMP_CFG = temp_act_reg;

   // Averaging filter, one per current/voltage channel
   for (genvar c = 0; c < N_AI; c++) begin : g_ai
      logic signed [15:0] hist [WIN_MAX];
      logic signed [15:0] smp_reg;
      logic signed [20:0] sum_reg;
      logic [4:0] ptr_reg;
      logic [4:0] fill_reg;
      logic [4:0] win_len;
      logic restart;
      logic signed [15:0] oldest;
      logic signed [20:0] avg;

      // 60 Hz window of 16.6 ms rounds down to 16 whole samples
      assign win_len = (ai_act_reg[c].supp == SUPP_60HZ) ? WIN_60HZ : WIN_50HZ;
      assign restart = (ai_pend_reg[c] != ai_act_reg[c]);
      assign oldest = (fill_reg == win_len) ? hist[ptr_reg] : 16'sh0000;
      assign avg = sum_reg / $signed({16'h0000, win_len});

      always_ff @(posedge REF_CLK) begin
         if (sample_tick) begin
            hist[restart ? 5'h00 : ptr_reg] <= $signed(AI_SAMPLE[c]);
         end
      end

      // Running sum drops the oldest sample once the window is full
      always_ff @(posedge REF_CLK) begin
         if (RESET) begin
            smp_reg <= '0;
            sum_reg <= '0;
            ptr_reg <= '0;
            fill_reg <= '0;
         end else if (sample_tick) begin
            smp_reg <= $signed(AI_SAMPLE[c]);
            if (restart) begin
               sum_reg <= 21'($signed(AI_SAMPLE[c])); // Fresh window
               ptr_reg <= 5'h01;
               fill_reg <= 5'h01;
            end else begin
               sum_reg <= sum_reg + 21'($signed(AI_SAMPLE[c])) - 21'(oldest);
               ptr_reg <= (ptr_reg == win_len - 5'h01) ? 5'h00 : ptr_reg + 5'h01;
               fill_reg <= (fill_reg == win_len) ? fill_reg : fill_reg + 5'h01;
            end
         end
      end

      // Word register changes only once per sample period
      always_ff @(posedge REF_CLK) begin
         if (RESET) begin
            ai_value_reg[c] <= '0;
         end else if (upd_reg) begin
            if (ai_act_reg[c].mtype == TYPE_DISABLED ||
                ai_act_reg[c].mrange == RANGE_DISABLED) begin
               ai_value_reg[c] <= DISABLED_VALUE;
            end else if (ai_act_reg[c].supp == SUPP_400HZ) begin
               ai_value_reg[c] <= smp_reg; // Filter bypassed
            end else if (fill_reg == win_len) begin
               ai_value_reg[c] <= avg[15:0];
            end else begin
               ai_value_reg[c] <= smp_reg; // Raw value while window refills
            end
         end
      end
   end

   // Temperature channel with unit conversion, values in 0.1 degree
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         temp_smp_reg <= '0;
         temp_value_reg <= '0;
      end else begin
         if (sample_tick) begin
            temp_smp_reg <= $signed(AI_SAMPLE[N_AI]);
         end
         if (upd_reg) begin
            if (temp_act_reg.mtype == TYPE_DISABLED ||
                temp_act_reg.mrange == TRANGE_DISABLED) begin
               temp_value_reg <= DISABLED_VALUE;
            end else if (temp_act_reg.unit == UNIT_FAHRENHEIT) begin
               temp_value_reg <= 16'((20'(temp_smp_reg) * F_MUL) / F_DIV + F_OFS);
            end else if (temp_act_reg.unit == UNIT_KELVIN) begin
               temp_value_reg <= 16'(20'(temp_smp_reg) + K_OFS);
            end else begin
               temp_value_reg <= temp_smp_reg;
            end
         end
      end
   end

   // Input word reads; an unmapped offset reads zero
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         RD_DATA <= '0;
      end else if (RD_EN) begin
         if (RD_ADDR == OFS_AI_CH0) begin
            RD_DATA <= ai_value_reg[0]; // Held value between samples
         end else if (RD_ADDR == OFS_AI_CH1) begin
            RD_DATA <= ai_value_reg[1];
         end else if (RD_ADDR == OFS_AI_CH2) begin
            RD_DATA <= ai_value_reg[2];
         end else if (RD_ADDR == OFS_AI_CH3) begin
            RD_DATA <= ai_value_reg[3];
         end else if (RD_ADDR == OFS_TEMP_CH4) begin
            RD_DATA <= temp_value_reg;
         end else begin
            RD_DATA <= '0;
         end
      end
   end

   // Output word writes; a disabled output is driven to zero
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         ao_val_reg <= '0;
         AO_VALUE <= '0;
      end else begin
         if (WR_EN && WR_ADDR == OFS_AO_CH0) begin
            ao_val_reg[0] <= WR_DATA;
         end else if (WR_EN && WR_ADDR == OFS_AO_CH1) begin
            ao_val_reg[1] <= WR_DATA;
         end
         for (int a = 0; a < N_AO; a++) begin
            AO_VALUE[a] <= (ao_cfg_reg[a].mtype == TYPE_DISABLED ||
                            ao_cfg_reg[a].mrange == RANGE_DISABLED) ? 16'h0000 : ao_val_reg[a];
         end
      end
   end

   assign AO_CFG = ao_cfg_reg;

   // Digital inputs: sync, debounce, edge events
   for (genvar i = 0; i < N_DI; i++) begin : g_di
      logic [2:0] sync_reg;
      logic [7:0] dly_cnt_reg;
      logic [7:0] dly_len;
      logic stable_reg;

      always_comb begin
         case (di_dly_reg[i / DI_GROUP])
            DLY_0MS1: dly_len = DLY_STEPS_0MS1;
            DLY_0MS5: dly_len = DLY_STEPS_0MS5;
            DLY_15MS: dly_len = DLY_STEPS_15MS;
            default: dly_len = DLY_STEPS_3MS;
         endcase
      end

      // A change counts once the second and third stages agree
      always_ff @(posedge REF_CLK) begin
         if (RESET) begin
            sync_reg <= '0;
            dly_cnt_reg <= '0;
            stable_reg <= 1'b0;
         end else begin
            sync_reg <= {sync_reg[1:0], DI_PIN[i]};
            if (sync_reg[1] == sync_reg[2] && sync_reg[2] != stable_reg) begin
               if (step_tick && dly_cnt_reg >= dly_len - 8'h01) begin
                  stable_reg <= sync_reg[2];
                  dly_cnt_reg <= '0;
               end else if (step_tick) begin
                  dly_cnt_reg <= dly_cnt_reg + 8'h01;
               end
            end else begin
               dly_cnt_reg <= '0; // Any bounce restarts the delay
            end
         end
      end

      // Pending event: set beats acknowledge, repeats are lost silently
      always_ff @(posedge REF_CLK) begin
         if (RESET) begin
            IRQ_PENDING[i] <= 1'b0;
            DI_STATE[i] <= 1'b0;
         end else begin
            DI_STATE[i] <= stable_reg; // Readable even under technology use
            if (sync_reg[1] == sync_reg[2] && sync_reg[2] != stable_reg && step_tick &&
                dly_cnt_reg >= dly_len - 8'h01 &&
                ((sync_reg[2] && rise_en_reg[i]) || (!sync_reg[2] && fall_en_reg[i]))) begin
               IRQ_PENDING[i] <= 1'b1;
            end else if (IRQ_ACK[i]) begin
               IRQ_PENDING[i] <= 1'b0;
            end
         end
      end
   end

   // Digital outputs carry no parameters; claimed bits follow the technology
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         do_user_reg <= '0;
         DO_PIN <= '0;
      end else begin
         if (DO_USER_WR) begin
            do_user_reg <= (DO_USER_DATA & ~TECH_DO_OWN) | (do_user_reg & TECH_DO_OWN);
         end
         DO_PIN <= (TECH_DO_VALUE & TECH_DO_OWN) | (do_user_reg & ~TECH_DO_OWN);
      end
   end

endmodule

// ---- iosc_chk.sv ----
`timescale 1ns/1ps
module iosc_chk
   import iosc_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RESET,
   input wire logic RD_EN,
   input wire logic [15:0] RD_DATA,
   input wire logic [N_AI-1:0][6:0] AI_CFG,
   input wire logic [N_AI-1:0][7:0] AI_INT_TIME,
   input wire logic [5:0] TEMP_CFG,
   input wire logic REC_START,
   input wire logic [7:0] REC_NUMBER,
   input wire logic REC_TARGET,
   input wire logic REC_BYTE_VALID,
   input wire logic REC_DONE,
   input wire logic REC_ERROR,
   input wire logic [N_DI-1:0] DI_STATE,
   input wire logic [N_DI-1:0] IRQ_PENDING,
   input wire logic [N_DI-1:0] IRQ_ACK,
   input wire logic DO_USER_WR,
   input wire logic [N_DO-1:0] DO_USER_DATA,
   input wire logic [N_DO-1:0] TECH_DO_OWN,
   input wire logic [N_DO-1:0] TECH_DO_VALUE,
   input wire logic [N_DO-1:0] DO_PIN
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RESET);
   logic [4:0] cnt_reg;
   logic tgt_reg;
   // Bytes since start; a start wins over a byte in the same cycle
   always_ff @(posedge REF_CLK) begin
      if (RESET || REC_START) begin
         cnt_reg <= 5'h00;
      end else if (REC_BYTE_VALID) begin
         cnt_reg <= cnt_reg + 5'h01;
      end
   end
   // Record kind
   always_ff @(posedge REF_CLK) begin
      if (REC_START) begin
         tgt_reg <= REC_TARGET;
      end
   end
   // User write with nothing claimed, then a quiet cycle
   sequence s_wr;
      DO_USER_WR && TECH_DO_OWN == '0;
   endsequence
   sequence s_quiet;
      !DO_USER_WR && TECH_DO_OWN == '0;
   endsequence
   chk_read_holds: assert property (!RD_EN |=> $stable(RD_DATA))
      else $error("read data moved");
   chk_cfg_defaults: assert property ($fell(RESET) |->
      AI_CFG == {N_AI{AI_CFG_DEFAULT}} && TEMP_CFG == TEMP_CFG_DEFAULT)
      else $error("bad defaults");
   chk_itime_follow: assert property (AI_INT_TIME[1] == (AI_CFG[1][6:5] == SUPP_400HZ ?
      ITIME_400HZ : AI_CFG[1][6:5] == SUPP_60HZ ? ITIME_60HZ : ITIME_50HZ))
      else $error("bad integration time");
   chk_rec_refused: assert property (REC_START && REC_NUMBER != REC_NUM_PARAM |=> REC_ERROR)
      else $error("record number not refused");
   chk_rec_length: assert property (REC_DONE |-> cnt_reg == (tgt_reg ? 5'h0D : 5'h0A))
      else $error("bad record length");
   chk_irq_held: assert property ((IRQ_PENDING & ~IRQ_ACK) != '0 |=>
      ($past(IRQ_PENDING) & ~$past(IRQ_ACK) & ~IRQ_PENDING) == '0)
      else $error("pending event lost");
   chk_irq_edge: assert property ((IRQ_PENDING & ~$past(IRQ_PENDING)) != '0 |=>
      ($past(IRQ_PENDING) & ~$past(IRQ_PENDING, 2) & ~(DI_STATE ^ $past(DI_STATE))) == '0)
      else $error("event without input change");
   chk_tech_owns: assert property (!$past(RESET) |->
      ((DO_PIN ^ $past(TECH_DO_VALUE)) & $past(TECH_DO_OWN)) == '0)
      else $error("claimed output not held");
   chk_user_out: assert property (s_wr ##1 s_quiet |=> DO_PIN == $past(DO_USER_DATA, 2))
      else $error("user output not applied");
endmodule
bind iosc_top iosc_chk i_iosc_chk (.REF_CLK, .RESET, .RD_EN, .RD_DATA, .AI_CFG, .AI_INT_TIME,
   .TEMP_CFG, .REC_START, .REC_NUMBER, .REC_TARGET, .REC_BYTE_VALID, .REC_DONE, .REC_ERROR,
   .DI_STATE, .IRQ_PENDING, .IRQ_ACK, .DO_USER_WR, .DO_USER_DATA, .TECH_DO_OWN,
   .TECH_DO_VALUE, .DO_PIN);

// ---- iosc_field_model.sv ----
`timescale 1ns/1ps
module iosc_field_model
   import iosc_pkg::*;
(
   input wire logic clk,
   input wire logic [N_AI:0][15:0] level,
   output logic [N_AI:0][15:0] sample
);
   // Transducers settle one clock after a new level
   always_ff @(posedge clk) begin
      sample <= level;
   end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
   import iosc_pkg::*;
   localparam int PER = 20 * SAMPLE_STEPS;
   logic clk, reset, rd_en, wr_en, rs, rt, rv, rdone, rerr, dwr;
   logic [3:0] ra, wa;
   logic [7:0] rn, rbyte;
   logic [7:0] rb [13];
   logic [15:0] rd_data, wd, dd, town, tval, do_pin;
   logic [N_DI-1:0] di, di_state, irq, ack;
   logic [N_AI:0][15:0] level, smp;
   logic [N_AI-1:0][6:0] ai_cfg;
   logic [N_AI-1:0][7:0] itime;
   logic [5:0] temp_cfg;
   logic [N_AO-1:0][4:0] ao_cfg;
   logic [N_AO-1:0][15:0] ao;
   int fail_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int ticks = 0;
   iosc_top #(.STEP_CYCLES_P(20)) i_iosc_top (.REF_CLK(clk), .RESET(reset), .AI_SAMPLE(smp),
      .AI_CFG(ai_cfg), .AI_INT_TIME(itime), .TEMP_CFG(temp_cfg), .AO_CFG(ao_cfg),
      .AO_VALUE(ao), .RD_EN(rd_en), .RD_ADDR(ra), .RD_DATA(rd_data), .WR_EN(wr_en),
      .WR_ADDR(wa), .WR_DATA(wd), .REC_START(rs), .REC_NUMBER(rn), .REC_TARGET(rt),
      .REC_BYTE_VALID(rv), .REC_BYTE(rbyte), .REC_DONE(rdone), .REC_ERROR(rerr), .DI_PIN(di),
      .DI_STATE(di_state), .IRQ_PENDING(irq), .IRQ_ACK(ack), .DO_USER_WR(dwr),
      .DO_USER_DATA(dd), .TECH_DO_OWN(town), .TECH_DO_VALUE(tval), .DO_PIN(do_pin));
   iosc_field_model i_iosc_field_model (.clk(clk), .level(level), .sample(smp));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Phase within the sample period, and a hang limit
   always @(posedge clk) begin
      cyc <= reset ? 0 : cyc + 1;
      ticks <= ticks + 1;
      if (ticks == 20000) begin
         fail_count++;
         close_out();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
      @(posedge clk);
      rd_en <= 1'b1;
      ra <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1 chk(n, e, rd_data);
   endtask
   task automatic rec(input logic [7:0] num, input logic tgt, input int len);
      @(posedge clk);
      rs <= 1'b1;
      rn <= num;
      rt <= tgt;
      for (int i = 0; i < len; i++) begin
         @(posedge clk);
         rs <= 1'b0;
         rv <= 1'b1;
         rbyte <= rb[i];
      end
      @(posedge clk);
      rs <= 1'b0;
      rv <= 1'b0;
      #1 chk("record end", 1, num == REC_NUM_PARAM ? rdone : rerr);
   endtask
   task automatic at_phase(input int p);
      do begin
         @(posedge clk);
      end while (cyc % PER != p);
   endtask
   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      {rd_en, ra, wr_en, wa, wd, rs, rn, rt, rv, rbyte, di, ack, dwr, dd, town, tval} = '0;
      reset = 1'b1; // Held in reset for sixteen cycles
      level = '0;
      level[4] = 16'h00FA;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1 chk("ai_cfg", {N_AI{AI_CFG_DEFAULT}}, ai_cfg);
      chk("itime", {N_AI{ITIME_50HZ}}, itime);
      chk("temp_cfg", TEMP_CFG_DEFAULT, temp_cfg);
      rd(4'hA, 16'h0000, "unmapped");
      @(posedge clk);
      wr_en <= 1'b1;
      wd <= 16'h0ABC;
      @(posedge clk);
      wa <= 4'h4;
      @(posedge clk);
      wr_en <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("ao", 32'h0000_0ABC, ao);
      // Unclaimed write, then claim, write, release
      @(posedge clk);
      dwr <= 1'b1;
      dd <= 16'h00C3;
      @(posedge clk);
      dwr <= 1'b0;
      @(posedge clk);
      town <= 16'h00FF;
      tval <= 16'h00A5;
      @(posedge clk);
      dwr <= 1'b1;
      dd <= 16'h1234;
      @(posedge clk);
      dwr <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("do owned", 16'h12A5, do_pin);
      @(posedge clk);
      town <= '0;
      repeat (2) @(posedge clk);
      #1 chk("do freed", 16'h12C3, do_pin);
      $display("test outputs finished");
      rec(8'h02, 1'b0, 0);
      foreach (rb[i]) rb[i] = i < 4 ? 8'h4C : 8'h0C;
      for (int u = 0; u < 3; u++) begin
         rb[4] = 8'h06 | 8'(u << 4);
         rec(8'h01, 1'b1, 13);
         repeat (2 * PER) @(posedge clk);
         rd(4'h8, u == 0 ? 16'h00FA : u == 1 ? 16'h0302 : 16'h0BA6, "temp");
      end
      rb[1] = 8'h0C;
      rb[2] = 8'h2C;
      rb[3] = 8'h44;
      rb[4] = 8'h06;
      rb[6] = 8'h00;
      rec(8'h01, 1'b1, 13);
      repeat (22 * PER) @(posedge clk);
      at_phase(160);
      level[2:0] <= {3{16'h0064}};
      at_phase(150);
      chk("itime1", ITIME_400HZ, itime[1]);
      chk("itime2", ITIME_60HZ, itime[2]);
      rd(4'h0, 16'h0005, "ch0");
      rd(4'h0, 16'h0005, "ch0 again");
      rd(4'h2, 16'h0064, "ch1");
      rd(4'h4, 16'h0006, "ch2");
      rd(4'h6, DISABLED_VALUE, "ch3");
      chk("ao_cfg", {5'h00, AO_CFG_DEFAULT}, ao_cfg);
      at_phase(150);
      at_phase(150);
      rd(4'h0, 16'h000F, "ch0 later");
      rd(4'h4, 16'h0012, "ch2 later");
      $display("test analog finished");
      rb[0] = 8'h28;
      rb[2] = 8'h01;
      {rb[3], rb[4], rb[5]} = '0;
      rec(8'h01, 1'b0, 10);
      @(posedge clk);
      di[0] <= 1'b1;
      di[8] <= 1'b1;
      repeat (60) @(posedge clk);
      #1 chk("di fast", 4'h5, {di_state[8], di_state[0], irq[8], irq[0]});
      repeat (440) @(posedge clk);
      #1 chk("di slow", 0, di_state[8]);
      repeat (200) @(posedge clk);
      #1 chk("di slow done", 2'h2, {di_state[8], irq[8]});
      @(posedge clk);
      di[0] <= 1'b0;
      repeat (60) @(posedge clk);
      di[0] <= 1'b1;
      repeat (60) @(posedge clk);
      ack[0] <= 1'b1;
      @(posedge clk);
      ack[0] <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("irq dropped", 0, irq[0]);
      $display("test inputs finished");
      close_out();
   end
endmodule
